/* verilog/pdc_core.sv */
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module pdc_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic [47:0] adc_raw,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output pdc_pkg::pdc_vec_t adc_mcm,
    output pdc_pkg::pdc_mon_t mon
);
    // clamps an eight-bit signed difference into the six-bit sample range
    function automatic pdc_pkg::pdc_smp_t sat6(input logic signed [7:0] v);
        if (v > 8'sh1F) begin
            sat6 = pdc_pkg::SMP_MAX;
        end else if (v < 8'shE0) begin
            sat6 = pdc_pkg::SMP_MIN;
        end else begin
            sat6 = v[5:0];
        end
    endfunction

    function automatic pdc_pkg::pdc_smp_t sat_sub(
        input pdc_pkg::pdc_smp_t a,
        input pdc_pkg::pdc_smp_t b
    );
        logic signed [7:0] d;
        d = {{2{a[5]}}, a} - {{2{b[5]}}, b}; // RQ1
        sat_sub = sat6(d); // RQ2
    endfunction

    // register file
    // map: 0x00 control, 0x04 mask, 0x08 thresholds, 0x0C and 0x10 hold
    // pedestals four to a word, 0x14 is read-only status; unmapped
    // writes are dropped and unmapped reads return zero
    pdc_pkg::pdc_cfg_t cfg_ff, nxt_cfg;
    logic [7:0] mask_ff, nxt_mask;
    pdc_pkg::pdc_smp_t hit_ff, nxt_hit;
    pdc_pkg::pdc_smp_t low_ff, nxt_low;
    pdc_pkg::pdc_vec_t ped_lvl_ff, nxt_ped_lvl;
    logic [31:0] rdata_ff, nxt_rdata;
    logic [5:0] tcnt_ff, nxt_tcnt;
    pdc_pkg::pdc_mon_t mon_ff, nxt_mon;

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_mask = mask_ff;
        nxt_hit = hit_ff;
        nxt_low = low_ff;
        nxt_ped_lvl = ped_lvl_ff;
        nxt_rdata = 32'h0000_0000;
        if (reg_wr) begin
            case (reg_addr)
                pdc_pkg::A_CTRL: begin
                    nxt_cfg.edge_fall = reg_wdata[pdc_pkg::CTRL_EDGE];
                    nxt_cfg.tcnt_en = reg_wdata[pdc_pkg::CTRL_TCNT];
                    nxt_cfg.invert = reg_wdata[pdc_pkg::CTRL_INV];
                    nxt_cfg.test_fill_select = reg_wdata[pdc_pkg::CTRL_FILL];
                    nxt_cfg.fill_value =
                        reg_wdata[pdc_pkg::CTRL_FILLV +: pdc_pkg::SMP_W];
                end
                pdc_pkg::A_MASK: begin
                    nxt_mask = reg_wdata[7:0];
                end
                pdc_pkg::A_THR: begin
                    nxt_hit = reg_wdata[pdc_pkg::THR_HIT +: pdc_pkg::SMP_W];
                    nxt_low = reg_wdata[pdc_pkg::THR_LOW +: pdc_pkg::SMP_W];
                end
                pdc_pkg::A_PED_LO: begin
                    for (int i = 0; i < 4; i++) begin
                        nxt_ped_lvl[i] =
                            reg_wdata[i*pdc_pkg::PED_STRIDE +: pdc_pkg::SMP_W];
                    end
                end
                pdc_pkg::A_PED_HI: begin
                    for (int i = 0; i < 4; i++) begin
                        nxt_ped_lvl[i+4] =
                            reg_wdata[i*pdc_pkg::PED_STRIDE +: pdc_pkg::SMP_W];
                    end
                end
                default: begin
                end
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                pdc_pkg::A_CTRL: begin
                    nxt_rdata[pdc_pkg::CTRL_EDGE] = cfg_ff.edge_fall;
                    nxt_rdata[pdc_pkg::CTRL_TCNT] = cfg_ff.tcnt_en;
                    nxt_rdata[pdc_pkg::CTRL_INV] = cfg_ff.invert;
                    nxt_rdata[pdc_pkg::CTRL_FILL] = cfg_ff.test_fill_select;
                    nxt_rdata[pdc_pkg::CTRL_FILLV +: pdc_pkg::SMP_W] =
                        cfg_ff.fill_value;
                end
                pdc_pkg::A_MASK: begin
                    nxt_rdata[7:0] = mask_ff;
                end
                pdc_pkg::A_THR: begin
                    nxt_rdata[pdc_pkg::THR_HIT +: pdc_pkg::SMP_W] = hit_ff;
                    nxt_rdata[pdc_pkg::THR_LOW +: pdc_pkg::SMP_W] = low_ff;
                end
                pdc_pkg::A_PED_LO: begin
                    for (int i = 0; i < 4; i++) begin
                        nxt_rdata[i*pdc_pkg::PED_STRIDE +: pdc_pkg::SMP_W] =
                            ped_lvl_ff[i];
                    end
                end
                pdc_pkg::A_PED_HI: begin
                    for (int i = 0; i < 4; i++) begin
                        nxt_rdata[i*pdc_pkg::PED_STRIDE +: pdc_pkg::SMP_W] =
                            ped_lvl_ff[i+4];
                    end
                end
                pdc_pkg::A_STATUS: begin
                    nxt_rdata[pdc_pkg::ST_CNT +: 4] = mon_ff.quiet_count;
                    nxt_rdata[pdc_pkg::ST_MEAN +: pdc_pkg::SMP_W] = mon_ff.mean;
                    nxt_rdata[pdc_pkg::ST_TCNT +: pdc_pkg::SMP_W] = tcnt_ff;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_ff <= pdc_pkg::CFG_RST;
            mask_ff <= pdc_pkg::MASK_RST;
            hit_ff <= pdc_pkg::HIT_RST;
            low_ff <= pdc_pkg::LOW_RST;
            ped_lvl_ff <= '0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            cfg_ff <= nxt_cfg;
            mask_ff <= nxt_mask;
            hit_ff <= nxt_hit;
            low_ff <= nxt_low;
            ped_lvl_ff <= nxt_ped_lvl;
            rdata_ff <= nxt_rdata;
        end
    end

    // test counter and capture
    // held at zero while disabled so each enable restarts the sequence
    // the counter enters ahead of both capture flops, so a clean sequence
    // at the output also proves the chosen capture edge
    // capture flops carry no reset; the pipeline reset covers what follows
    logic [47:0] cap_src;
    logic [47:0] cap_rise_ff, cap_fall_ff, sy_rise_ff, sy_fall_ff;
    pdc_pkg::pdc_vec_t adc_sync;

    always_comb begin
        nxt_tcnt = pdc_pkg::TCNT_RST; // RQ5
        if (cfg_ff.tcnt_en) begin
            // inverted OR term lets the all-zero start state move on
            nxt_tcnt = {tcnt_ff[4:0],
                tcnt_ff[5] ^ tcnt_ff[4] ^ ~(|tcnt_ff[4:0])}; // RQ6
        end
        cap_src = cfg_ff.tcnt_en ? {pdc_pkg::CH_NUM{tcnt_ff}} : adc_raw; // RQ25
        adc_sync = cfg_ff.edge_fall ? sy_fall_ff : sy_rise_ff; // RQ3
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            tcnt_ff <= pdc_pkg::TCNT_RST;
        end else begin
            tcnt_ff <= nxt_tcnt;
        end
        cap_rise_ff <= cap_src;
        sy_rise_ff <= cap_rise_ff;
        sy_fall_ff <= cap_fall_ff;
    end

    // falling-edge capture gives half a period of margin against the skew
    always_ff @(negedge clk) begin
        cap_fall_ff <= cap_src; // RQ3
    end

    // pedestal stage
    // settings are not staged per sample: a write lands on whatever is in
    // flight, so allow a full flush before trusting the output
    pdc_pkg::pdc_vec_t ped_ff, nxt_ped;
    logic [7:0] ped_msk_ff;
    pdc_pkg::pdc_smp_t ped_in, ped_inv;

    always_comb begin
        nxt_ped = '0;
        ped_in = '0;
        ped_inv = '0;
        for (int i = 0; i < pdc_pkg::CH_NUM; i++) begin // RQ12
            // masked inputs held at zero, or at the fill value when fill is selected, so the arithmetic stays quiet
            ped_in = mask_ff[i] ? 6'sh00 : adc_sync[i]; // RQ11
            if (cfg_ff.test_fill_select) begin
                ped_in = cfg_ff.fill_value;
            end
            ped_inv = cfg_ff.invert ? sat_sub(6'sh00, ped_in) : ped_in; // RQ8 RQ23
            nxt_ped[i] = mask_ff[i] ? 6'sh00 :
                sat_sub(ped_inv, ped_lvl_ff[i]); // RQ9 RQ10
        end
    end

    // quiet count and sum
    // channel pairs register first, the four pair sums register second
    logic [1:0] cs_cnt1_ff [0:3];
    logic [1:0] nxt_cs_cnt1 [0:3];
    logic signed [6:0] cs_sum1_ff [0:3];
    logic signed [6:0] nxt_cs_sum1 [0:3];
    logic [3:0] cs_cnt2_ff, nxt_cs_cnt2;
    logic signed [9:0] cs_sum2_ff, nxt_cs_sum2;
    logic [7:0] quiet_channel_flag;

    always_comb begin
        for (int i = 0; i < pdc_pkg::CH_NUM; i++) begin
            // low threshold inclusive, hit threshold exclusive
            quiet_channel_flag[i] = !ped_msk_ff[i] && (ped_ff[i] >= low_ff)
                && (ped_ff[i] < hit_ff); // RQ13 RQ14 RQ15
        end
        nxt_cs_cnt2 = 4'h0;
        nxt_cs_sum2 = 10'sh000;
        for (int p = 0; p < 4; p++) begin // RQ16
            nxt_cs_cnt1[p] = 2'({1'b0, quiet_channel_flag[2*p]})
                + 2'({1'b0, quiet_channel_flag[2*p+1]});
            nxt_cs_sum1[p] =
                (quiet_channel_flag[2*p] ? 7'(ped_ff[2*p]) : 7'sh00)
                + (quiet_channel_flag[2*p+1] ? 7'(ped_ff[2*p+1]) : 7'sh00);
            nxt_cs_cnt2 = nxt_cs_cnt2 + 4'(cs_cnt1_ff[p]);
            nxt_cs_sum2 = nxt_cs_sum2 + 10'(cs_sum1_ff[p]);
        end
    end

    // divider
    // stage 0 forms 2|s|+c over 2c so floor gives round half away from zero
    // stages 1 to 3 settle two quotient bits each and the monitor register
    // applies sign and clamp, five cycles in all
    // every channel lies in -32..31, so the quotient never passes 32
    logic [9:0] dv_rem_ff [0:3];
    logic [9:0] nxt_dv_rem [0:3];
    logic [5:0] dv_quo_ff [0:3];
    logic [5:0] nxt_dv_quo [0:3];
    logic [4:0] dv_den_ff [0:3];
    logic [4:0] nxt_dv_den [0:3];
    logic [3:0] dv_cnt_ff [0:3];
    logic [3:0] nxt_dv_cnt [0:3];
    logic [3:0] dv_neg_ff, nxt_dv_neg;
    logic [8:0] sum_abs;
    logic [9:0] dv_shift;
    logic signed [7:0] dv_signed;

    always_comb begin
        sum_abs = cs_sum2_ff[9] ? 9'(-cs_sum2_ff) : cs_sum2_ff[8:0];
        nxt_dv_rem[0] = {sum_abs, 1'b0} + 10'(cs_cnt2_ff); // RQ18 RQ24
        nxt_dv_den[0] = {cs_cnt2_ff, 1'b0};
        nxt_dv_quo[0] = 6'h00;
        nxt_dv_cnt[0] = cs_cnt2_ff;
        nxt_dv_neg[0] = cs_sum2_ff[9];
        dv_shift = 10'h000;
        for (int k = 1; k < 4; k++) begin // RQ17
            nxt_dv_rem[k] = dv_rem_ff[k-1];
            nxt_dv_quo[k] = dv_quo_ff[k-1];
            nxt_dv_den[k] = dv_den_ff[k-1];
            nxt_dv_cnt[k] = dv_cnt_ff[k-1];
            nxt_dv_neg[k] = dv_neg_ff[k-1];
            for (int b = 7 - 2*k; b >= 6 - 2*k; b--) begin
                dv_shift = 10'(dv_den_ff[k-1]) << b;
                if (nxt_dv_rem[k] >= dv_shift) begin
                    nxt_dv_rem[k] = nxt_dv_rem[k] - dv_shift;
                    nxt_dv_quo[k][b] = 1'b1;
                end
            end
        end
        dv_signed = dv_neg_ff[3] ? -8'({2'b00, dv_quo_ff[3]}) :
            8'({2'b00, dv_quo_ff[3]});
        nxt_mon.mean = (dv_cnt_ff[3] == 4'h0) ? 6'sh00 : sat6(dv_signed); // RQ24
        nxt_mon.quiet_count = dv_cnt_ff[3]; // RQ21
    end

    // delay line and final subtraction
    // the mask rides beside the data so a mask change never splits a sample
    // loaded beside ped_ff so entry 6 meets the mean as it leaves the divider
    pdc_pkg::pdc_vec_t dly_ff [0:pdc_pkg::DLY_DEPTH-1];
    logic [7:0] dly_msk_ff [0:pdc_pkg::DLY_DEPTH-1];
    pdc_pkg::pdc_vec_t mcm_ff, nxt_mcm;

    always_comb begin
        for (int i = 0; i < pdc_pkg::CH_NUM; i++) begin
            nxt_mcm[i] = dly_msk_ff[pdc_pkg::DLY_DEPTH-1][i] ? 6'sh00 :
                sat_sub(dly_ff[pdc_pkg::DLY_DEPTH-1][i], nxt_mon.mean); // RQ20
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ped_ff <= '0;
            ped_msk_ff <= 8'h00;
            cs_cnt2_ff <= 4'h0;
            cs_sum2_ff <= 10'sh000;
            dv_neg_ff <= 4'h0;
            mon_ff <= '0;
            mcm_ff <= '0;
            for (int p = 0; p < 4; p++) begin
                cs_cnt1_ff[p] <= 2'h0;
                cs_sum1_ff[p] <= 7'sh00;
                dv_rem_ff[p] <= 10'h000;
                dv_quo_ff[p] <= 6'h00;
                dv_den_ff[p] <= 5'h00;
                dv_cnt_ff[p] <= 4'h0;
            end
            for (int d = 0; d < pdc_pkg::DLY_DEPTH; d++) begin
                dly_ff[d] <= '0;
                dly_msk_ff[d] <= 8'h00;
            end
        end else begin
            ped_ff <= nxt_ped; // RQ22
            ped_msk_ff <= mask_ff;
            cs_cnt2_ff <= nxt_cs_cnt2;
            cs_sum2_ff <= nxt_cs_sum2;
            dv_neg_ff <= nxt_dv_neg;
            mon_ff <= nxt_mon;
            mcm_ff <= nxt_mcm; // RQ22
            for (int p = 0; p < 4; p++) begin
                cs_cnt1_ff[p] <= nxt_cs_cnt1[p];
                cs_sum1_ff[p] <= nxt_cs_sum1[p];
                dv_rem_ff[p] <= nxt_dv_rem[p];
                dv_quo_ff[p] <= nxt_dv_quo[p];
                dv_den_ff[p] <= nxt_dv_den[p];
                dv_cnt_ff[p] <= nxt_dv_cnt[p];
            end
            dly_ff[0] <= nxt_ped; // RQ19
            dly_msk_ff[0] <= mask_ff;
            for (int d = 1; d < pdc_pkg::DLY_DEPTH; d++) begin
                dly_ff[d] <= dly_ff[d-1];
                dly_msk_ff[d] <= dly_msk_ff[d-1];
            end
        end
    end

    assign reg_rdata = rdata_ff;
    assign adc_mcm = mcm_ff;
    assign mon = mon_ff;
endmodule

/* verilog/pdc_pkg.sv */
// Notes on behaviour
// RQ1: converter samples are signed six-bit two's-complement values throughout.
// RQ2: every subtraction saturates to the range -32 to 31.
// RQ3: capture on rising main-clock edge when edge select is 0, falling when 1.
// RQ4: software picks falling for phase 0-7, rising 8-39, falling 40-63.
// RQ5: test counter enable makes the pseudo-random counter supply samples, from zero.
// RQ6: counter shifts bits 4:0 up; new bit mixes bit 5, bit 4, OR of 4:0 (the code XORs bit 5, bit 4 and the inverted OR of 4:0).
// RQ7: software keeps the constant fill select at zero in normal running.
// RQ8: polarity flip inverts each aligned sample arithmetically before pedestal step.
// RQ9: unmasked channel output is sample minus its pedestal, saturated.
// RQ10: a masked channel leaves the pedestal stage as zero.
// RQ11: the mask also blocks the pedestal stage input to stop needless toggling (the code lets the fill value through when fill is selected).
// RQ12: eight channels per cycle, each with its own pedestal and mask.
// RQ13: quiet means unmasked, at least low-reject threshold, below hit threshold.
// RQ14: low-reject threshold at minimum rejects no channel.
// RQ15: hit threshold at minimum makes quiet count and mean zero.
// RQ16: quiet count and quiet sum come from a two-cycle pipeline.
// RQ17: the divider yields the mean five cycles after the count and sum.
// RQ18: mean is signed six-bit, quiet sum over count rounded to nearest.
// RQ19: corrected samples wait in a seven-entry delay to meet their mean.
// RQ20: final output zero when masked, else sample minus mean, saturated.
// RQ21: quiet count and mean are forwarded to the packet builder.
// RQ22: pedestal stage takes one cycle, common-mode stage seven.
// RQ23: inverting -32 gives 31 instead of overflowing.
// RQ24: half-way quotients round away from zero; zero count gives zero mean.
// RQ25: enabled test counter replaces the converter output for all channels.
package pdc_pkg;
    localparam int CH_NUM = 8;
    localparam int SMP_W = 6;
    localparam int SUM_LAT = 2;
    localparam int DIV_LAT = 5;
    localparam int DLY_DEPTH = SUM_LAT + DIV_LAT;

    typedef logic signed [5:0] pdc_smp_t;
    typedef pdc_smp_t [7:0] pdc_vec_t;

    localparam pdc_smp_t SMP_MAX = 6'sh1F;
    localparam pdc_smp_t SMP_MIN = 6'sh20;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_MASK = 8'h04;
    localparam logic [7:0] A_THR = 8'h08;
    localparam logic [7:0] A_PED_LO = 8'h0C;
    localparam logic [7:0] A_PED_HI = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;

    localparam int CTRL_EDGE = 0;
    localparam int CTRL_TCNT = 1;
    localparam int CTRL_INV = 2;
    localparam int CTRL_FILL = 3;
    localparam int CTRL_FILLV = 8;
    localparam int THR_HIT = 0;
    localparam int THR_LOW = 8;
    localparam int PED_STRIDE = 8;
    localparam int ST_CNT = 0;
    localparam int ST_MEAN = 8;
    localparam int ST_TCNT = 16;

    localparam logic [7:0] MASK_RST = 8'h00;
    localparam pdc_smp_t HIT_RST = 6'sh00;
    localparam pdc_smp_t LOW_RST = 6'sh20;
    localparam logic [5:0] TCNT_RST = 6'h00;

    typedef struct packed {
        logic edge_fall;
        logic tcnt_en;
        logic invert;
        logic test_fill_select;
        pdc_smp_t fill_value;
    } pdc_cfg_t;

    localparam pdc_cfg_t CFG_RST = '{1'b0, 1'b0, 1'b0, 1'b0, 6'sh00};

    typedef struct packed {
        logic [3:0] quiet_count;
        pdc_smp_t mean;
    } pdc_mon_t;
endpackage

/* sim/pdc_core_monitor.sv */
`timescale 1ns/10ps
module pdc_core_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire logic [47:0] adc_raw,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire pdc_pkg::pdc_vec_t adc_mcm,
    input wire pdc_pkg::pdc_mon_t mon
);
    logic [7:0] mask_ff, nxt_mask, masked_nz;
    logic tcnt_ff, nxt_tcnt;
    logic [5:0] hit_ff, nxt_hit;
    logic [3:0] cfg_age_ff, nxt_cfg_age, st_age_ff, nxt_st_age;
    logic [47:0] raw_ff;

    function automatic logic [5:0] step(input logic [5:0] c);
        return {c[4:0], c[5] ^ c[4] ^ ~|c[4:0]};
    endfunction

    // the ages hold the mask, quiet, steady, hit and status checks off until the pipeline has flushed
    always_comb begin
        nxt_mask = mask_ff;
        nxt_tcnt = tcnt_ff;
        nxt_hit = hit_ff;
        if (reg_wr && reg_addr == pdc_pkg::A_MASK) begin
            nxt_mask = reg_wdata[7:0];
        end
        if (reg_wr && reg_addr == pdc_pkg::A_CTRL) begin
            nxt_tcnt = reg_wdata[pdc_pkg::CTRL_TCNT];
        end
        if (reg_wr && reg_addr == pdc_pkg::A_THR) begin
            nxt_hit = reg_wdata[5:0];
        end
        nxt_cfg_age = cfg_age_ff + {3'h0, cfg_age_ff != 4'hF};
        nxt_st_age = st_age_ff + {3'h0, st_age_ff != 4'hF};
        if (reg_wr) begin
            nxt_cfg_age = 4'h0;
        end
        if (reg_wr || tcnt_ff || adc_raw != raw_ff) begin
            nxt_st_age = 4'h0;
        end
        for (int i = 0; i < 8; i++) begin
            masked_nz[i] = mask_ff[i] && adc_mcm[i] != 6'sh00;
        end
    end

    always_ff @(posedge clk) begin
        raw_ff <= adc_raw;
        if (srst) begin
            mask_ff <= 8'h00;
            tcnt_ff <= 1'b0;
            hit_ff <= pdc_pkg::HIT_RST;
            cfg_age_ff <= 4'h0;
            st_age_ff <= 4'h0;
        end else begin
            mask_ff <= nxt_mask;
            tcnt_ff <= nxt_tcnt;
            hit_ff <= nxt_hit;
            cfg_age_ff <= nxt_cfg_age;
            st_age_ff <= nxt_st_age;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    AST_MEAN_EMPTY: assert property (
        mon.quiet_count == 4'h0 |-> mon.mean == 6'sh00)
        else $error("mean not zero with no quiet channel");
    AST_COUNT_MAX: assert property (mon.quiet_count <= 4'h8)
        else $error("quiet count above eight");
    AST_MASK_ZERO: assert property (
        cfg_age_ff >= 4'hB |-> masked_nz == 8'h00)
        else $error("masked channel not zero");
    AST_QUIET_UNMASKED: assert property (
        cfg_age_ff >= 4'hB |-> mon.quiet_count <= $countones(~mask_ff))
        else $error("quiet count above unmasked channels");
    AST_STEADY: assert property (
        st_age_ff >= 4'hC |-> $stable(adc_mcm) && $stable(mon))
        else $error("output moved with steady input");
    AST_HIT_OFF: assert property (
        hit_ff == pdc_pkg::SMP_MIN && cfg_age_ff >= 4'hB |-> mon == 10'h000)
        else $error("common mode active with minimum hit threshold");
    AST_TCNT_STEP: assert property (
        reg_rd && reg_addr == pdc_pkg::A_STATUS && tcnt_ff ##1
        reg_rd && reg_addr == pdc_pkg::A_STATUS |=>
        reg_rdata[21:16] == step($past(reg_rdata[21:16])))
        else $error("test counter step wrong");
    AST_STATUS_MON: assert property (
        reg_rd && reg_addr == pdc_pkg::A_STATUS && st_age_ff >= 4'hC |=>
        reg_rdata[3:0] == mon.quiet_count && reg_rdata[13:8] == mon.mean)
        else $error("status differs from monitor output");

    cover property (mon.quiet_count == 4'h0 && hit_ff == pdc_pkg::SMP_MIN);
    cover property (mon.mean[5] && mon.quiet_count > 4'h1);
    cover property (tcnt_ff && cfg_age_ff == 4'hF);
endmodule

bind pdc_core pdc_core_monitor pdc_core_monitor_i (.clk(clk), .srst(srst),
    .adc_raw(adc_raw), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_mcm(adc_mcm), .mon(mon));

/* sim/pdc_adc_model.sv */
`timescale 1ns/10ps
module pdc_adc_model (
    input wire logic clk,
    input wire pdc_pkg::pdc_vec_t code,
    output logic [47:0] adc_raw
);
    // codes settle just after the main edge and hold a whole cycle, so
    // both capture edges see a clean value
    always @(posedge clk) begin
        adc_raw <= code;
    end
endmodule

/* sim/tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata, d;
    logic [47:0] adc_raw, prev;
    logic [57:0] e;
    pdc_pkg::pdc_vec_t code = 48'h0;
    pdc_pkg::pdc_vec_t rv = {6'h14, 6'h3F, 6'h00, 6'h0A, 6'h3B, 6'h05,
        6'h20, 6'h1F};
    pdc_pkg::pdc_vec_t adc_mcm;
    pdc_pkg::pdc_mon_t mon;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;

    always #25 clk = ~clk;

    pdc_adc_model pdc_adc_model_i (.clk(clk), .code(code), .adc_raw(adc_raw));
    pdc_core pdc_core_i (.clk(clk), .srst(srst), .adc_raw(adc_raw),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_mcm(adc_mcm),
        .mon(mon));

    task automatic report_and_stop;
        if (bad_count == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    function automatic int sat(input int v);
        return v > 31 ? 31 : (v < -32 ? -32 : v);
    endfunction

    function automatic logic [5:0] step(input logic [5:0] c);
        return {c[4:0], c[5] ^ c[4] ^ ~|c[4:0]};
    endfunction

    // returns {quiet count, mean, eight final samples}
    function automatic logic [57:0] model(input logic [31:0] ctrl,
        input logic [7:0] mask, input logic [31:0] thr,
        input logic [63:0] ped, input pdc_pkg::pdc_vec_t raw);
        int p [8];
        int s, sum, cnt, mean;
        logic [57:0] r;
        sum = 0;
        cnt = 0;
        for (int i = 0; i < 8; i++) begin
            s = ctrl[3] ? $signed(ctrl[13:8]) : raw[i];
            s = ctrl[2] ? sat(-s) : s;
            p[i] = mask[i] ? 0 : sat(s - $signed(ped[8*i +: 6]));
            if (!mask[i] && p[i] >= $signed(thr[13:8]) &&
                p[i] < $signed(thr[5:0])) begin
                sum += p[i];
                cnt++;
            end
        end
        mean = (cnt == 0) ? 0 : (sum < 0 ? -1 : 1) *
            ((2 * (sum < 0 ? -sum : sum) + cnt) / (2 * cnt));
        for (int i = 0; i < 8; i++) begin
            r[6*i +: 6] = mask[i] ? 6'h00 : 6'(sat(p[i] - mean));
        end
        r[57:48] = {4'(cnt), 6'(mean)};
        return r;
    endfunction

    task automatic run_case(input logic [31:0] ctrl, input logic [7:0] mask,
        input logic [31:0] thr, input logic [63:0] ped,
        input pdc_pkg::pdc_vec_t raw);
        wr(pdc_pkg::A_CTRL, ctrl);
        wr(pdc_pkg::A_MASK, {24'h0, mask});
        wr(pdc_pkg::A_THR, thr);
        wr(pdc_pkg::A_PED_LO, ped[31:0]);
        wr(pdc_pkg::A_PED_HI, ped[63:32]);
        code <= raw;
        repeat (16) @(posedge clk);
        #1 e = model(ctrl, mask, thr, ped, raw);
        chk(adc_mcm, e[47:0]);
        chk({38'h0, mon}, {38'h0, e[57:48]});
        rd(pdc_pkg::A_STATUS, d);
        chk({16'h0, d}, {34'h0, e[53:48], 4'h0, e[57:54]});
    endtask

    // falling capture suits a converter phase below 8, rising mid range
    task automatic lat_case(input logic fall);
        run_case({31'h0, fall}, 8'h00, 32'h2020, 64'h0, {8{6'h05}});
        code <= {8{6'h3A}};
        repeat (fall ? 9 : 10) @(posedge clk);
        #1 chk(adc_mcm, {8{6'h05}});
        @(posedge clk);
        #1 chk(adc_mcm, {8{6'h3A}});
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        wr(pdc_pkg::A_STATUS, 32'hFFFFFFFF);
        wr(8'h18, 32'hFFFFFFFF);
        for (int a = 0; a < 7; a++) begin
            rd(8'(4 * a), d);
            chk({16'h0, d}, (a == 2) ? 48'h2000 : 48'h0);
        end
        run_case(32'h0, 8'h80, 32'h201F, 64'h3D030A36, rv);
        run_case(32'h4, 8'h00, 32'h201F, 64'h0, rv);
        run_case(32'h0, 8'h00, 32'h2020, 64'h0, rv);
        run_case(32'h0, 8'h00, 32'h3E05, 64'h0, {{3{6'h0A}}, 6'h05, 6'h0A,
            6'h3D, 6'h3E, 6'h3F});
        run_case(32'h2C0C, 8'h00, 32'h201F, 64'h0, rv);
        run_case(32'h0, 8'hFF, 32'h201F, 64'h1F1F1F1F, rv);
        lat_case(1'b0);
        lat_case(1'b1);
        wr(pdc_pkg::A_CTRL, 32'h2);
        repeat (14) @(posedge clk);
        #1 prev = adc_mcm;
        repeat (8) begin
            @(posedge clk);
            #1 chk(adc_mcm, {8{step(prev[5:0])}});
            prev = adc_mcm;
        end
        @(posedge clk);
        reg_addr <= pdc_pkg::A_STATUS;
        reg_rd <= 1'b1;
        @(posedge clk);
        #1 d = reg_rdata;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk({42'h0, reg_rdata[21:16]}, {42'h0, step(d[21:16])});
        wr(pdc_pkg::A_CTRL, 32'h0);
        report_and_stop();
    end
endmodule
